// ---- src/ccd_defines.svh ----
// Register offsets, field positions and reset values of the channel clock divider
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH
`define CCD_IDX_DIV1_CTRL 12'h194
`define CCD_IDX_CH1_CFG 12'h195
`define CCD_IDX_DIV2_CNT 12'h196
`define CCD_IDX_DIV2_CTRL 12'h197
`define CCD_IDX_SRC_SEL 12'h1E1
`define CCD_IDX_STATUS 12'h1F0
`define CCD_BIT_NOSYNC 6
`define CCD_BIT_FORCE 5
`define CCD_BIT_START 4
`define CCD_PHASE_HI 3
`define CCD_PHASE_LO 0
`define CCD_BIT_PDN 2
`define CCD_BIT_DIRECT 1
`define CCD_BIT_NODCC 0
`define CCD_BIT_BYPASS 7
`define CCD_LOW_HI 7
`define CCD_LOW_LO 4
`define CCD_HIGH_HI 3
`define CCD_HIGH_LO 0
`define CCD_RST_DIV1_CTRL 8'h00
`define CCD_RST_CH1_CFG 8'h00
`define CCD_RST_DIV2_CNT 8'h11
`define CCD_RST_DIV2_CTRL 8'h00
`define CCD_RST_SRC_SEL 2'h0
`define CCD_SRC_OSC 2'h2
`define CCD_SRC_EXT 2'h0
`endif

// ---- src/ccd_pkg.sv ----
// Types shared by the channel clock divider files
package ccd_pkg;
  typedef enum logic [1:0] {
    CCD_RUN = 2'b00,
    CCD_PHASE = 2'b01,
    CCD_FORCED = 2'b10
  } ccd_state_t;
  typedef enum logic [1:0] {
    CCD_ROUTE_DIV = 2'b00,
    CCD_ROUTE_OSC = 2'b01,
    CCD_ROUTE_EXT = 2'b10
  } ccd_route_t;
endpackage

// ---- src/ccd_sync2.sv ----
// Two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module ccd_sync2 (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  // Only the second stage is read outside this module
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else if (en_i) begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ---- src/ccd_counter.sv ----
// Divider phase counter: low and high half counts, phase delay and restart
`timescale 1ns/1ps
`include "ccd_defines.svh"
module ccd_counter import ccd_pkg::*; #(
  parameter int CW = 4
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic restart_i,
  input wire logic forced_i,
  input wire logic force_lvl_i,
  input wire logic start_lvl_i,
  input wire logic [CW-1:0] phase_i,
  input wire logic [CW-1:0] low_i,
  input wire logic [CW-1:0] high_i,
  output logic out_o,
  output ccd_state_t state_o
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic lvl_d;
  ccd_state_t st_d;
  // Count limit of the current half: low or high count
  wire logic [CW-1:0] half_lim = out_o ? high_i : low_i;
  wire logic half_end = (cnt_q >= half_lim);

  always_comb begin
    st_d = state_o;
    cnt_d = cnt_q;
    lvl_d = out_o;
    if (forced_i) begin
      st_d = CCD_FORCED;
      lvl_d = force_lvl_i;
      cnt_d = '0;
    end else if (restart_i || state_o == CCD_FORCED) begin
      st_d = CCD_PHASE;
      lvl_d = start_lvl_i;
      cnt_d = '0;
    end else begin
      case (state_o)
        CCD_PHASE: begin
          // Phase offset delays the first transition, in input cycles
          if (cnt_q >= phase_i) begin
            st_d = CCD_RUN;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        CCD_RUN: begin
          if (half_end) begin
            lvl_d = ~out_o;
            cnt_d = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        default: begin
          st_d = CCD_RUN;
          cnt_d = '0;
        end
      endcase
    end
  end

  // Low lasts low_i+1 cycles, high lasts high_i+1 cycles
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      out_o <= 1'b0;
      state_o <= CCD_PHASE;
    end else if (en_i) begin
      cnt_q <= cnt_d; // RL9 RL10 RL13
      out_o <= lvl_d;
      state_o <= st_d;
    end
  end
endmodule

// ---- src/ccd_top.sv ----
// Channel clock divider: APB registers, divider, channel routing and outputs
// What this block does
// RL1 - Control bit 6 set ignores chip sync
// RL2 - Bit 5 forces level when sync ignored
// RL3 - Bit 4 picks start level after restart
// RL4 - Bits 3:0 hold phase offset, reset zero
// RL5 - Channel bit 2 powers down three outputs
// RL6 - Channel bit 1 clear routes divider out
// RL7 - Direct routing picks oscillator or external clock
// RL8 - Channel bit 0 set disables duty correction
// RL9 - Low time is upper nibble plus one
// RL10 - High time is lower nibble plus one
// RL11 - Divider 2 counts reset to one each
// RL12 - Bypass bit 7 passes input straight through
// RL13 - Unmasked sync restarts with phase offset
`timescale 1ns/1ps
`include "ccd_defines.svh"
module ccd_top import ccd_pkg::*; #(
  parameter int CW = 4
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_b_i,
  input wire logic osc_clk_i,
  input wire logic ext_clk_i,
  output logic group_one_output_a_o,
  output logic group_one_output_b_o,
  output logic group_one_output_c_o,
  output logic duty_cycle_correction_o
);
  // Register file
  logic [7:0] div1_ctrl_q;
  logic [7:0] ch1_cfg_q;
  logic [7:0] div2_cnt_q;
  logic [7:0] div2_ctrl_q;
  logic [1:0] src_sel_q;
  ccd_route_t route_q;
  logic sync_s;
  logic osc_s;
  logic ext_s;
  logic sync_s_q;
  logic div_out;
  ccd_state_t div_state;
  logic out_d;

  // Pin inputs are resynchronised before any logic reads them
  ccd_sync2 u_sync_sync (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .en_i(clk_en_i),
    .d_i(sync_b_i),
    .q_o(sync_s)
  );
  ccd_sync2 u_sync_osc (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .en_i(clk_en_i),
    .d_i(osc_clk_i),
    .q_o(osc_s)
  );
  ccd_sync2 u_sync_ext (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .en_i(clk_en_i),
    .d_i(ext_clk_i),
    .q_o(ext_s)
  );

  // APB decode: byte address is four times the register index
  wire logic [11:0] reg_idx = paddr[13:2];
  wire logic addr_hi_zero = (paddr[31:14] == 18'h0) && (paddr[1:0] == 2'h0);
  wire logic hit_div1_ctrl = addr_hi_zero && (reg_idx == `CCD_IDX_DIV1_CTRL);
  wire logic hit_ch1_cfg = addr_hi_zero && (reg_idx == `CCD_IDX_CH1_CFG);
  wire logic hit_div2_cnt = addr_hi_zero && (reg_idx == `CCD_IDX_DIV2_CNT);
  wire logic hit_div2_ctrl = addr_hi_zero && (reg_idx == `CCD_IDX_DIV2_CTRL);
  wire logic hit_src_sel = addr_hi_zero && (reg_idx == `CCD_IDX_SRC_SEL);
  wire logic hit_status = addr_hi_zero && (reg_idx == `CCD_IDX_STATUS);
  wire logic hit_any = hit_div1_ctrl | hit_ch1_cfg | hit_div2_cnt | hit_div2_ctrl | hit_src_sel | hit_status;
  wire logic setup = psel && !penable;
  wire logic acc = psel && penable && pready;
  wire logic wr = acc && pwrite && hit_any;
  // Status shows block state: output level, divider state, route
  wire logic [7:0] status_val = {2'h0, route_q, div_state, div_out, group_one_output_a_o};
  wire logic [31:0] rd_mux =
    hit_div1_ctrl ? {24'h000000, div1_ctrl_q} :
    hit_ch1_cfg ? {24'h000000, ch1_cfg_q} :
    hit_div2_cnt ? {24'h000000, div2_cnt_q} :
    hit_div2_ctrl ? {24'h000000, div2_ctrl_q} :
    hit_src_sel ? {30'h0, src_sel_q} :
    hit_status ? {24'h000000, status_val} : 32'h00000000;

  // No wait state: pready rises in the first access cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (clk_en_i) begin
      pready <= setup;
      prdata <= setup ? rd_mux : 32'h00000000;
      pslverr <= setup && !hit_any;
    end
  end

  // Register writes take effect at the completing access edge
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div1_ctrl_q <= `CCD_RST_DIV1_CTRL; // RL4
      ch1_cfg_q <= `CCD_RST_CH1_CFG;
      div2_cnt_q <= `CCD_RST_DIV2_CNT; // RL11
      div2_ctrl_q <= `CCD_RST_DIV2_CTRL;
      src_sel_q <= `CCD_RST_SRC_SEL;
    end else if (clk_en_i && wr) begin
      if (hit_div1_ctrl) div1_ctrl_q <= pwdata[7:0];
      if (hit_ch1_cfg) ch1_cfg_q <= pwdata[7:0];
      if (hit_div2_cnt) div2_cnt_q <= pwdata[7:0];
      if (hit_div2_ctrl) div2_ctrl_q <= pwdata[7:0];
      if (hit_src_sel) src_sel_q <= pwdata[1:0];
    end
  end

  // Sync is active low; a falling edge is one sync event
  // Resets like the synchroniser so that leaving reset is not seen as an edge
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_s_q <= 1'b0;
    end else if (clk_en_i) begin
      sync_s_q <= sync_s;
    end
  end

  wire logic no_sync = div1_ctrl_q[`CCD_BIT_NOSYNC];
  wire logic sync_evt = sync_s_q && !sync_s && !no_sync; // RL1 RL13
  // Ignoring sync holds the divider at the force bit level, high or low
  wire logic forced = no_sync; // RL2
  // Bypass input clock, not counted by the divider: the clock that direct routing also uses
  wire logic div_in = (route_q == CCD_ROUTE_OSC) ? osc_s : ext_s;
  wire logic bypass = div2_ctrl_q[`CCD_BIT_BYPASS];

  // Divider counter; held while bypassed to model power-down
  ccd_counter #(
    .CW(CW)
  ) u_div (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .en_i(clk_en_i && !bypass),
    .restart_i(sync_evt),
    .forced_i(forced),
    .force_lvl_i(div1_ctrl_q[`CCD_BIT_FORCE]), // RL2
    .start_lvl_i(div1_ctrl_q[`CCD_BIT_START]), // RL3
    .phase_i(div1_ctrl_q[`CCD_PHASE_HI:`CCD_PHASE_LO]), // RL4
    .low_i(div2_cnt_q[`CCD_LOW_HI:`CCD_LOW_LO]), // RL9
    .high_i(div2_cnt_q[`CCD_HIGH_HI:`CCD_HIGH_LO]), // RL10
    .out_o(div_out),
    .state_o(div_state)
  );

  // Route is updated only by 10b or 00b; 01b keeps the last choice
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      route_q <= CCD_ROUTE_EXT;
    end else if (clk_en_i) begin
      if (src_sel_q == `CCD_SRC_OSC) route_q <= CCD_ROUTE_OSC; // RL7
      else if (src_sel_q == `CCD_SRC_EXT) route_q <= CCD_ROUTE_EXT; // RL7
    end
  end

  wire logic forced_lvl = div1_ctrl_q[`CCD_BIT_FORCE];
  wire logic div_path = bypass ? div_in : (forced ? forced_lvl : div_out); // RL12
  wire logic direct = ch1_cfg_q[`CCD_BIT_DIRECT];
  wire logic pdn = ch1_cfg_q[`CCD_BIT_PDN];
  // Powered-down outputs sit low, the safe idle level
  assign out_d = pdn ? 1'b0 : (direct ? div_in : div_path); // RL5 RL6 RL7

  // Outputs are registered; one cycle of latency after the selection
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      group_one_output_a_o <= 1'b0;
      group_one_output_b_o <= 1'b0;
      group_one_output_c_o <= 1'b0;
      duty_cycle_correction_o <= 1'b1;
    end else if (clk_en_i) begin
      group_one_output_a_o <= out_d; // RL5 RL6
      group_one_output_b_o <= out_d;
      group_one_output_c_o <= out_d;
      duty_cycle_correction_o <= !ch1_cfg_q[`CCD_BIT_NODCC]; // RL8
    end
  end
endmodule

// ---- test/ccd_monitor.sv ----
// Port checker for the channel clock divider
`timescale 1ns/1ps
module ccd_monitor (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic group_one_output_a_o,
  input wire logic group_one_output_b_o,
  input wire logic group_one_output_c_o,
  input wire logic duty_cycle_correction_o
);
  logic [7:0] ctl_q;
  logic [7:0] cfg_q;
  logic byp_q;
  wire wr_w = psel & penable & pready & pwrite & clk_en_i;
  wire frc_w = ctl_q[6] & ~cfg_q[2] & ~cfg_q[1] & ~byp_q;
  // Shadows of committed writes; refused writes never hit a mapped address
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_q <= 8'h00;
      cfg_q <= 8'h00;
      byp_q <= 1'b0;
    end else if (wr_w) begin
      if (paddr == 32'h650) ctl_q <= pwdata[7:0];
      if (paddr == 32'h654) cfg_q <= pwdata[7:0];
      if (paddr == 32'h65C) byp_q <= pwdata[7];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Force must hold with an unchanged level before the output is judged
  sequence s_forced; (frc_w && $stable(ctl_q[5])) [*4]; endsequence
  property p_ans; psel && !penable && clk_en_i |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; pready && clk_en_i |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stray data");
  property p_same; group_one_output_a_o == group_one_output_b_o
    && group_one_output_a_o == group_one_output_c_o; endproperty
  a_same: assert property (p_same) else $error("outputs differ");
  property p_pdn; cfg_q[2] [*4] |-> !group_one_output_a_o; endproperty
  a_pdn: assert property (p_pdn) else $error("not powered down");
  property p_force; s_forced |-> group_one_output_a_o == ctl_q[5]; endproperty
  a_force: assert property (p_force) else $error("bad forced level");
  property p_dcc; $stable(cfg_q[0]) [*2] |-> duty_cycle_correction_o == !cfg_q[0]; endproperty
  a_dcc: assert property (p_dcc) else $error("bad correction flag");
  // Clock enable low freezes every registered output
  property p_hold; !clk_en_i |=> $stable(group_one_output_a_o) && $stable(pready)
    && $stable(duty_cycle_correction_o); endproperty
  a_hold: assert property (p_hold) else $error("state moved while frozen");
endmodule
bind ccd_top ccd_monitor ccd_monitor_i (.clock_i, .rst_b_i, .clk_en_i, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .group_one_output_a_o, .group_one_output_b_o, .group_one_output_c_o,
  .duty_cycle_correction_o);

// ---- test/ccd_rx_model.sv ----
// Downstream receiver model: run lengths of one output level
`timescale 1ns/1ps
module ccd_rx_model (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic level_i,
  output logic [7:0] low_len_o,
  output logic [7:0] high_len_o
);
  logic [7:0] run_q;
  logic last_q;
  // A run closes on a level change and is held until the next run of that level
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q <= 8'h01;
      last_q <= 1'b0;
      low_len_o <= 8'h00;
      high_len_o <= 8'h00;
    end else begin
      last_q <= level_i;
      run_q <= (level_i != last_q) ? 8'h01 : run_q + 8'h01;
      if (level_i != last_q && last_q) high_len_o <= run_q;
      if (level_i != last_q && !last_q) low_len_o <= run_q;
    end
  end
endmodule

// ---- test/tb_channel_clock_divider.sv ----
// Self-checking bench for the channel clock divider
`timescale 1ns/1ps
module tb_channel_clock_divider;
  logic clock_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sync_b_i = 1'b1, osc_clk_i = 1'b0, ext_clk_i = 1'b0, clk_en_i = 1'b1, pready, pslverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [3:0] outs;
  logic [7:0] low_len, high_len;
  logic [19:0] seen;
  int err_count = 0, num_checks = 0;
  always #10 clock_i = ~clock_i;
  // Mid-cycle snapshot so checks never race the edge that moves the outputs
  always @(negedge clock_i) seen = {high_len, low_len, outs};
  ccd_top ccd_top_i (.clock_i, .rst_b_i, .clk_en_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sync_b_i, .osc_clk_i, .ext_clk_i, .group_one_output_a_o(outs[0]),
    .group_one_output_b_o(outs[1]), .group_one_output_c_o(outs[2]), .duty_cycle_correction_o(outs[3]));
  ccd_rx_model ccd_rx_model_i (.clock_i, .rst_b_i, .level_i(outs[0]), .low_len_o(low_len), .high_len_o(high_len));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One APB transfer after an idle cycle, so psel is never driven twice in one step
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [32:0] re);
    int n;
    n = 0;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock_i);
    penable <= 1'b1;
    // Request stands until the edge at which pready is sampled high
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    re = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [32:0] re;
    apb(1'b1, a, d, re);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Reset values, then an unmapped read refused with zero data
  task automatic t_reset();
    logic [31:0] adr[6] = '{32'h650, 32'h654, 32'h658, 32'h65C, 32'h784, 32'h700};
    logic [32:0] exp[6] = '{33'h0, 33'h0, 33'h11, 33'h0, 33'h0, 33'h100000000};
    logic [32:0] re;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, adr[i], 8'h00, re);
      chk(re, exp[i]);
    end
    $display("test reset done");
  endtask
  task automatic t_period();
    logic [3:0] frz;
    wt(20);
    chk(seen[19:4], 16'h0202);
    wr(32'h658, 8'h31);
    wt(30);
    chk(seen[19:4], 16'h0204);
    // Enable low over more than one period: a running divider must not move
    clk_en_i <= 1'b0;
    wt(2);
    frz = seen[3:0];
    wt(8);
    chk(seen[3:0], frz);
    clk_en_i <= 1'b1;
    $display("test period done");
  endtask
  // Long phase offset keeps the start level well past the sync latency
  task automatic t_sync();
    for (int s = 0; s < 2; s++) begin
      wr(32'h650, {3'h0, s[0], 4'hF});
      sync_b_i <= 1'b0;
      wt(8);
      chk(seen[0], s[0]);
      sync_b_i <= 1'b1;
      wt(10);
      chk(seen[0], s[0]);
    end
    $display("test sync done");
  endtask
  task automatic t_force();
    wr(32'h650, 8'h5F);
    sync_b_i <= 1'b0;
    wt(8);
    chk(seen[2:0], 3'h0);
    sync_b_i <= 1'b1;
    wr(32'h650, 8'h7F);
    wt(4);
    chk(seen[2:0], 3'h7);
    wr(32'h650, 8'h20);
    wt(30);
    chk(seen[19:4], 16'h0204);
    $display("test force done");
  endtask
  task automatic t_route();
    osc_clk_i <= 1'b1;
    wr(32'h784, 8'h02);
    wr(32'h654, 8'h02);
    wt(6);
    chk(seen[3:0], 4'hF);
    wr(32'h784, 8'h00);
    wt(6);
    chk(seen[3:0], 4'h8);
    ext_clk_i <= 1'b1;
    osc_clk_i <= 1'b0;
    wr(32'h784, 8'h01);
    wt(6);
    chk(seen[3:0], 4'hF);
    wr(32'h654, 8'h06);
    wt(6);
    chk(seen[3:0], 4'h8);
    wr(32'h654, 8'h01);
    wr(32'h65C, 8'h80);
    wt(6);
    chk(seen[3:0], 4'h7);
    ext_clk_i <= 1'b0;
    wt(6);
    chk(seen[3:0], 4'h0);
    $display("test route done");
  endtask
  initial begin
    wt(10);
    rst_b_i <= 1'b1;
    t_reset();
    t_period();
    t_sync();
    t_force();
    t_route();
    complete_run();
  end
endmodule
